// ### rtl/lamp_driver.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Steady green when ready or checking I/O
// - Green flashes 2 s while init/restart/download
// - Steady red on fatal hardware or watchdog
// - Red flashes 1 s on communications/bus error
// - Dark without power or awaiting init
// - Lamp combines own and link condition
// - Relay-driving output: lamp follows on/off
// - Current output: lamp lit when MV above 0
// - One lamp per output, same number
module status_and_output_lamp_driver #(
   parameter int TICK_DIV = lamp_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // Conditions from control logic
   input wire lamp_pkg::unit_cond_s unit_cond_in,
   input wire lamp_pkg::ctrl_out_s [lamp_pkg::NUM_OUTPUTS-1:0] ctrl_out_in,
   // Lamps
   output logic lamp_green_out,
   output logic lamp_red_out,
   output logic [lamp_pkg::NUM_OUTPUTS-1:0] out_lamp_out,
   // Interrupt
   output logic irq_out
);
   import lamp_pkg::*;

   lamp_state_e state_ff;
   lamp_state_e nxt_state;
   logic [31:0] tick_cnt_ff;
   logic tick_ff;
   logic [10:0] ms_cnt_ff;
   logic fatal;
   logic comm;
   logic fatal_ff;
   logic comm_ff;
   logic green_ff;
   logic red_ff;
   logic [NUM_OUTPUTS-1:0] out_lamp_ff;
   logic [NUM_OUTPUTS-1:0] nxt_out_lamp;
   logic [NUM_OUTPUTS-1:0] out_mode_ff;
   logic [IRQ_WIDTH-1:0] irq_status_ff;
   logic [IRQ_WIDTH-1:0] irq_mask_ff;
   logic [IRQ_WIDTH-1:0] irq_event;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic req;
   logic wr;
   logic [31:0] rd_data;

   // Fatal conditions common to all units
   assign fatal = unit_cond_in.hw_failure
                | unit_cond_in.watchdog_timeout
                | unit_cond_in.fatal_other;

   // Link-side errors shared with every module
   assign comm = unit_cond_in.comm_error
               | unit_cond_in.bus_error;

   // Status lamp selection, highest priority first
   always_comb begin
      if (!unit_cond_in.power_ok) begin
         nxt_state = LAMP_DARK;
      end else if (fatal) begin
         nxt_state = LAMP_RED;
      end else if (comm) begin
         nxt_state = LAMP_RED_FLASH;
      end else if (unit_cond_in.initializing
                   | unit_cond_in.restarting
                   | unit_cond_in.downloading) begin
         nxt_state = LAMP_GREEN_FLASH;
      end else if (unit_cond_in.waiting_init) begin
         nxt_state = LAMP_DARK;
      end else if (unit_cond_in.ready | unit_cond_in.io_check) begin
         nxt_state = LAMP_GREEN;
      end else begin
         nxt_state = LAMP_DARK;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= LAMP_DARK;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Millisecond enable pulse from the clock divider
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         tick_cnt_ff <= 32'h0;
         tick_ff <= 1'b0;
      end else if (tick_cnt_ff == 32'(TICK_DIV - 1)) begin
         tick_cnt_ff <= 32'h0;
         tick_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h1;
         tick_ff <= 1'b0;
      end
   end

   // Flash phase counter; restarts on entry so a flash opens lit
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ms_cnt_ff <= 11'h0;
      end else if (nxt_state != state_ff) begin
         ms_cnt_ff <= 11'h0;
      end else if (tick_ff) begin
         if (state_ff == LAMP_GREEN_FLASH
             && ms_cnt_ff == 11'(2 * GREEN_HALF_TICKS - 11'h1)) begin
            ms_cnt_ff <= 11'h0;
         end else if (state_ff == LAMP_RED_FLASH
                      && ms_cnt_ff == 11'(2 * RED_HALF_TICKS - 11'h1)) begin
            ms_cnt_ff <= 11'h0;
         end else begin
            ms_cnt_ff <= ms_cnt_ff + 11'h1;
         end
      end
   end

   // Lamp drive, registered to keep the pins glitch free
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         green_ff <= 1'b0;
         red_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            LAMP_DARK: begin
               green_ff <= 1'b0;
               red_ff <= 1'b0;
            end
            LAMP_GREEN: begin
               green_ff <= 1'b1;
               red_ff <= 1'b0;
            end
            LAMP_GREEN_FLASH: begin
               green_ff <= (ms_cnt_ff < GREEN_HALF_TICKS);
               red_ff <= 1'b0;
            end
            LAMP_RED: begin
               green_ff <= 1'b0;
               red_ff <= 1'b1;
            end
            LAMP_RED_FLASH: begin
               green_ff <= 1'b0;
               red_ff <= (ms_cnt_ff < RED_HALF_TICKS);
            end
            default: begin
               green_ff <= 1'b0;
               red_ff <= 1'b0;
            end
         endcase
      end
   end

   assign lamp_green_out = green_ff;
   assign lamp_red_out = red_ff;

   // Per-output lamps; mode bit 1 selects current output
   generate
      for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
         always_comb begin
            if (out_mode_ff[i]) begin
               nxt_out_lamp[i] = (ctrl_out_in[i].mv > 0);
            end else begin
               nxt_out_lamp[i] = ctrl_out_in[i].on;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         out_lamp_ff <= '0;
      end else begin
         out_lamp_ff <= nxt_out_lamp;
      end
   end

   assign out_lamp_out = out_lamp_ff;

   // Rising edges of error classes and status lamp changes
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         fatal_ff <= 1'b0;
         comm_ff <= 1'b0;
      end else begin
         fatal_ff <= fatal;
         comm_ff <= comm;
      end
   end

   always_comb begin
      irq_event = '0;
      irq_event[IRQ_FATAL_BIT] = fatal & ~fatal_ff;
      irq_event[IRQ_COMM_BIT] = comm & ~comm_ff;
      irq_event[IRQ_CHANGE_BIT] = (nxt_state != state_ff);
   end

   // Wishbone request decode
   assign req = wb_cyc_in & wb_stb_in & ~ack_ff;
   assign wr = req & wb_we_in & wb_sel_in[0];

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req;
      end
   end

   // Output mode register
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         out_mode_ff <= OUT_MODE_RESET;
      end else if (wr && wb_adr_in == ADDR_OUT_MODE) begin
         out_mode_ff <= wb_dat_in[NUM_OUTPUTS-1:0];
      end
   end

   // Interrupt mask register
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         irq_mask_ff <= IRQ_MASK_RESET;
      end else if (wr && wb_adr_in == ADDR_IRQ_MASK) begin
         irq_mask_ff <= wb_dat_in[IRQ_WIDTH-1:0];
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         irq_status_ff <= '0;
      end else if (wr && wb_adr_in == ADDR_IRQ_STATUS) begin
         irq_status_ff <= (irq_status_ff & ~wb_dat_in[IRQ_WIDTH-1:0])
                        | irq_event;
      end else begin
         irq_status_ff <= irq_status_ff | irq_event;
      end
   end

   assign irq_out = |(irq_status_ff & irq_mask_ff);

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_data = 32'h0;
      unique case (wb_adr_in)
         ADDR_LAMP_STATE: begin
            rd_data[LS_STATE_LSB +: 3] = state_ff;
            rd_data[LS_GREEN_BIT] = green_ff;
            rd_data[LS_RED_BIT] = red_ff;
            rd_data[LS_OUT_LSB +: NUM_OUTPUTS] = out_lamp_ff;
         end
         ADDR_OUT_MODE: begin
            rd_data[NUM_OUTPUTS-1:0] = out_mode_ff;
         end
         ADDR_IRQ_STATUS: begin
            rd_data[IRQ_WIDTH-1:0] = irq_status_ff;
         end
         ADDR_IRQ_MASK: begin
            rd_data[IRQ_WIDTH-1:0] = irq_mask_ff;
         end
         default: begin
            rd_data = 32'h0;
         end
      endcase
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         dat_ff <= 32'h0;
      end else if (req) begin
         dat_ff <= rd_data;
      end
   end

   assign wb_dat_out = dat_ff;
   assign wb_ack_out = ack_ff;

endmodule // status_and_output_lamp_driver

// ### include/lamp_pkg.sv
package lamp_pkg;

   // Clock and time base
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

   // Flash periods in ms, lit for the first half
   localparam int GREEN_FLASH_MS = 2000;
   localparam int RED_FLASH_MS = 1000;
   localparam logic [10:0] GREEN_HALF_TICKS = 11'(GREEN_FLASH_MS / 2 / TICK_MS);
   localparam logic [10:0] RED_HALF_TICKS = 11'(RED_FLASH_MS / 2 / TICK_MS);

   // Control outputs and manipulated variable
   localparam int NUM_OUTPUTS = 8;
   localparam int MV_WIDTH = 16;

   // Register word addresses (byte offsets)
   localparam logic [7:0] ADDR_LAMP_STATE = 8'h00;
   localparam logic [7:0] ADDR_OUT_MODE = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

   // Reset values
   localparam logic [NUM_OUTPUTS-1:0] OUT_MODE_RESET = 8'h00;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

   // Interrupt status bit positions
   localparam int IRQ_FATAL_BIT = 0;
   localparam int IRQ_COMM_BIT = 1;
   localparam int IRQ_CHANGE_BIT = 2;
   localparam int IRQ_WIDTH = 3;

   // Lamp state readback field positions
   localparam int LS_STATE_LSB = 0;
   localparam int LS_GREEN_BIT = 4;
   localparam int LS_RED_BIT = 5;
   localparam int LS_OUT_LSB = 8;

   typedef enum logic [2:0] {
      LAMP_DARK,
      LAMP_GREEN,
      LAMP_GREEN_FLASH,
      LAMP_RED,
      LAMP_RED_FLASH
   } lamp_state_e;

   // Module condition flags from the control logic
   typedef struct packed {
      logic power_ok;
      logic initializing;
      logic restarting;
      logic downloading;
      logic waiting_init;
      logic ready;
      logic io_check;
      logic hw_failure;
      logic watchdog_timeout;
      logic fatal_other;
      logic comm_error;
      logic bus_error;
   } unit_cond_s;

   // One control output as seen by its lamp
   typedef struct packed {
      logic on;
      logic signed [MV_WIDTH-1:0] mv;
   } ctrl_out_s;

endpackage

// ### testbench/lamp_driver_sva.sv
`timescale 1ns/100ps
module lamp_driver_sva
   import lamp_pkg::*;
#(
   parameter int TICK_DIV = 4
) (
   // Clock, reset, bus
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   // Conditions and lamps
   input wire unit_cond_s unit_cond_in,
   input wire ctrl_out_s [NUM_OUTPUTS-1:0] ctrl_out_in,
   input wire logic lamp_green_out,
   input wire logic lamp_red_out,
   input wire logic [NUM_OUTPUTS-1:0] out_lamp_out,
   input wire logic irq_out
);
   logic [NUM_OUTPUTS-1:0] mode_ff, on_v, pos_v;
   logic pwr, fatal, comm, boot;
   assign pwr = unit_cond_in.power_ok;
   assign fatal = unit_cond_in.hw_failure | unit_cond_in.watchdog_timeout | unit_cond_in.fatal_other;
   assign comm = unit_cond_in.comm_error | unit_cond_in.bus_error;
   assign boot = unit_cond_in.initializing | unit_cond_in.restarting | unit_cond_in.downloading;
   always_comb begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
         on_v[i] = ctrl_out_in[i].on;
         pos_v[i] = ctrl_out_in[i].mv > 0;
      end
   end
   // Shadow of the mode register, taken at the same edge as the design
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         mode_ff <= '0;
      end else if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0] && wb_adr_in == ADDR_OUT_MODE) begin
         mode_ff <= wb_dat_in[NUM_OUTPUTS-1:0];
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   chk_ack_pulse: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
      else $error("ack not one pulse");
   chk_fatal_red: assert property ((pwr && fatal) [*3] |-> lamp_red_out && !lamp_green_out)
      else $error("fatal not steady red");
   chk_unpowered_dark: assert property ((!pwr) [*3] |-> !lamp_red_out && !lamp_green_out)
      else $error("unpowered lamp lit");
   chk_ready_green: assert property ((pwr && !fatal && !comm && !boot && !unit_cond_in.waiting_init
      && (unit_cond_in.ready || unit_cond_in.io_check)) [*3] |-> lamp_green_out && !lamp_red_out)
      else $error("ready not steady green");
   chk_comm_red: assert property ((pwr && comm) [*3] |-> !lamp_green_out)
      else $error("green during error");
   chk_boot_green: assert property ((pwr && boot && !fatal && !comm) [*3] |-> !lamp_red_out)
      else $error("red during start");
   chk_relay_lamp: assert property (!$past(rst_in) |-> ((out_lamp_out ^ $past(on_v)) & ~$past(mode_ff)) == '0)
      else $error("relay lamp wrong");
   chk_current_lamp: assert property (!$past(rst_in) |-> ((out_lamp_out ^ $past(pos_v)) & $past(mode_ff)) == '0)
      else $error("current lamp wrong");
endmodule // lamp_driver_sva

// ### testbench/lamp_panel_model.sv
`timescale 1ns/100ps
module lamp_panel_model (
   // Clock and lamp
   input wire logic clock_in,
   input wire logic lamp_in,
   // Cycles of the last finished stretch
   output logic [15:0] last_run_out
);
   logic [15:0] run_ff = '0;
   logic seen_ff = 1'b0;
   always_ff @(posedge clock_in) begin
      seen_ff <= lamp_in;
      if (lamp_in != seen_ff) begin
         last_run_out <= run_ff;
         run_ff <= 16'h0001;
      end else begin
         run_ff <= run_ff + 16'h0001;
      end
   end
endmodule // lamp_panel_model

// ### testbench/status_and_output_lamp_driver_tb_top.sv
`timescale 1ns/100ps
module status_and_output_lamp_driver_tb_top;
   import lamp_pkg::*;
   localparam int TICK = 4;
   logic clock_in = 1'b0, rst_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = '0, olamp;
   logic [3:0] sel = '0;
   logic [31:0] wdat = '0, rdat, q;
   logic ack, green, red, irq;
   logic [15:0] g_run, r_run;
   unit_cond_s cond = '0;
   ctrl_out_s [NUM_OUTPUTS-1:0] ctrl = '0;
   int fail_count = 0, tests_run = 0;
   initial forever #20 clock_in = ~clock_in;
   status_and_output_lamp_driver #(.TICK_DIV(TICK)) DUT (.clock_in(clock_in), .rst_in(rst_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .unit_cond_in(cond), .ctrl_out_in(ctrl),
      .lamp_green_out(green), .lamp_red_out(red), .out_lamp_out(olamp), .irq_out(irq));
   lamp_panel_model u_gp (.clock_in(clock_in), .lamp_in(green), .last_run_out(g_run));
   lamp_panel_model u_rp (.clock_in(clock_in), .lamp_in(red), .last_run_out(r_run));
   task conclude;
      $display("mismatches %0d comparisons %0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clock_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         $display("wrong value at %0t: got %h expected %h", $time, ack, 1'b1);
         fail_count++;
         conclude();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task wait_lamp(input logic r, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while ((r ? red : green) !== v && n < 5000);
      if ((r ? red : green) !== v) begin
         $display("wrong value at %0t: got %h expected %h", $time, r ? red : green, v);
         fail_count++;
         conclude();
      end
   endtask
   task regs_irq;
      bus(1'b1, ADDR_OUT_MODE, 32'hff, 4'he);
      bus(1'b0, ADDR_OUT_MODE, '0, 4'hf);
      check(q, 32'h0);
      bus(1'b1, 8'h10, 32'hff, 4'hf);
      bus(1'b0, 8'h10, '0, 4'hf);
      check(q, 32'h0);
      bus(1'b0, ADDR_IRQ_MASK, '0, 4'hf);
      check(q, 32'h0);
      cond <= 12'h840;
      repeat (3) @(posedge clock_in);
      bus(1'b1, ADDR_IRQ_STATUS, 32'h7, 4'hf);
      cond <= 12'h810;
      repeat (3) @(posedge clock_in);
      bus(1'b0, ADDR_IRQ_STATUS, '0, 4'hf);
      check(q, 32'h5);
      check(irq, 1'b0);
      bus(1'b1, ADDR_IRQ_MASK, 32'h1, 4'hf);
      check(irq, 1'b1);
      bus(1'b1, ADDR_IRQ_STATUS, 32'h1, 4'hf);
      check(irq, 1'b0);
      cond <= 12'h802;
      repeat (3) @(posedge clock_in);
      bus(1'b0, ADDR_IRQ_STATUS, '0, 4'hf);
      check(q, 32'h6);
      check(irq, 1'b0);
      bus(1'b1, ADDR_IRQ_MASK, 32'h4, 4'hf);
      check(irq, 1'b1);
      bus(1'b0, ADDR_IRQ_MASK, '0, 4'hf);
      check(q, 32'h4);
   endtask
   task status_table;
      logic [11:0] c [15] = '{12'h000, 12'h840, 12'h820, 12'h880, 12'hc00, 12'ha00, 12'h900, 12'h810,
         12'h808, 12'h804, 12'h802, 12'h801, 12'h812, 12'hc02, 12'h050};
      lamp_state_e s [15] = '{LAMP_DARK, LAMP_GREEN, LAMP_GREEN, LAMP_DARK, LAMP_GREEN_FLASH,
         LAMP_GREEN_FLASH, LAMP_GREEN_FLASH, LAMP_RED, LAMP_RED, LAMP_RED, LAMP_RED_FLASH,
         LAMP_RED_FLASH, LAMP_RED, LAMP_RED_FLASH, LAMP_DARK};
      logic g, r;
      for (int i = 0; i < 15; i++) begin
         cond <= c[i];
         repeat (3) @(posedge clock_in);
         g = s[i] == LAMP_GREEN || s[i] == LAMP_GREEN_FLASH;
         r = s[i] == LAMP_RED || s[i] == LAMP_RED_FLASH;
         check({red, green}, {r, g});
         bus(1'b0, ADDR_LAMP_STATE, '0, 4'hf);
         check(q[5:0], {r, g, 1'b0, s[i]});
      end
   endtask
   task flash(input logic [11:0] c, input logic r, input int half);
      cond <= '0;
      repeat (3) @(posedge clock_in);
      cond <= c;
      wait_lamp(r, 1'b1);
      wait_lamp(r, 1'b0);
      // First lit stretch may be short by up to one tick; time the steady ones
      wait_lamp(r, 1'b1);
      @(posedge clock_in);
      check(r ? r_run : g_run, half);
      wait_lamp(r, 1'b0);
      @(posedge clock_in);
      check(r ? r_run : g_run, half);
   endtask
   task out_lamps;
      logic signed [15:0] m [8] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'hffff, 16'h0000,
         16'h0001, 16'h8000};
      logic [7:0] e;
      bus(1'b1, ADDR_OUT_MODE, 32'hf0, 4'hf);
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
         ctrl[i].on <= i[0];
         ctrl[i].mv <= m[i];
         e[i] = i < 4 ? i[0] : m[i] > 0;
      end
      repeat (2) @(posedge clock_in);
      check(olamp, e);
      bus(1'b0, ADDR_LAMP_STATE, '0, 4'hf);
      check(q[15:8], e);
      bus(1'b1, ADDR_OUT_MODE, '0, 4'hf);
      repeat (2) @(posedge clock_in);
      check(olamp, 8'haa);
   endtask
   initial begin
      repeat (4) @(posedge clock_in);
      rst_in <= 1'b0;
      regs_irq();
      status_table();
      flash(12'h802, 1'b1, int'(RED_HALF_TICKS) * TICK);
      flash(12'hc00, 1'b0, int'(GREEN_HALF_TICKS) * TICK);
      out_lamps();
      conclude();
   end
endmodule // status_and_output_lamp_driver_tb_top
bind status_and_output_lamp_driver lamp_driver_sva #(.TICK_DIV(TICK_DIV)) u_chk (.clock_in(clock_in),
   .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
   .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .unit_cond_in(unit_cond_in), .ctrl_out_in(ctrl_out_in),
   .lamp_green_out(lamp_green_out), .lamp_red_out(lamp_red_out), .out_lamp_out(out_lamp_out),
   .irq_out(irq_out));
